// [hw/crr_pkg.sv]
// Package: register map, field layout and encodings of the reverse config and status slice
package crr_pkg;
  localparam logic [7:0] ADDR_THERM_CTRL   = 8'h1D;
  localparam logic [7:0] ADDR_UV_CTRL      = 8'h1E;
  localparam logic [7:0] ADDR_MPP_LOW      = 8'h1F;
  localparam logic [7:0] ADDR_MPP_HIGH     = 8'h20;
  localparam logic [7:0] ADDR_STATUS_ONE   = 8'h21;
  localparam logic [7:0] ADDR_STATUS_TWO   = 8'h22;
  localparam logic [7:0] ADDR_STATUS_THREE = 8'h23;

  localparam logic [1:0] HOT_55C     = 2'h0;
  localparam logic [1:0] HOT_60C     = 2'h1;
  localparam logic [1:0] HOT_65C     = 2'h2;
  localparam logic [1:0] HOT_DISABLE = 2'h3;
  localparam logic [1:0] HOT_RESET   = HOT_60C;
  localparam logic       COLD_RESET  = 1'h0;
  localparam logic       UV_RESET    = 1'h0;

  localparam int HOT_MSB  = 7;
  localparam int HOT_LSB  = 6;
  localparam int COLD_BIT = 5;
  localparam int UV_BIT   = 5;

  localparam int         MPP_LSB   = 2;
  localparam int         MPP_W     = 12;
  localparam logic [11:0] MPP_MAX  = 12'hBB8;

  typedef enum logic [2:0] {
    CRR_CHG_IDLE = 3'h0, CRR_CHG_TRICKLE = 3'h1, CRR_CHG_PRE = 3'h2, CRR_CHG_CC = 3'h3,
    CRR_CHG_CV = 3'h4, CRR_CHG_RSVD = 3'h5, CRR_CHG_TOPOFF = 3'h6, CRR_CHG_DONE = 3'h7
  } crr_charge_t;

  typedef enum logic [2:0] {
    CRR_TS_NORMAL = 3'h0, CRR_TS_WARM = 3'h1, CRR_TS_COOL = 3'h2, CRR_TS_COLD = 3'h3,
    CRR_TS_HOT = 3'h4
  } crr_zone_t;

  typedef enum logic [1:0] {
    CRR_SYNC_NONE = 2'h0, CRR_SYNC_VALID = 2'h1, CRR_SYNC_FAULT = 2'h2, CRR_SYNC_RSVD = 2'h3
  } crr_sync_t;
endpackage

// [hw/crr_regs.sv]
// Reverse-mode threshold and status register slice of the charge controller
//
// Functional notes
// - Hot threshold bits 7:6: 55C, 60C, 65C, disabled; resets to 60C.
// - Cold threshold bit 5: zero is -10C, one is -20C; resets zero.
// - Undervoltage bit 5: zero trips at 80 percent, one at 3.3V.
// - Peak-power voltage: upper byte at higher address, lower byte at lower.
// - Peak-power voltage in bits 13:2, 20mV steps, clamped at BB8h, zero at reset.
// - Status one bit 7 shows one-shot conversion complete.
// - Status one bit 6 shows input current regulation, pin or programmed limit.
// - Status one bit 5 shows input voltage or reverse system regulation.
// - Status one bit 3 shows watchdog expired, clear otherwise.
// - Status one bits 2:0 carry the charge state code.
// - Status two bit 7 shows input power good.
// - Status two bits 6:4 carry the thermistor zone.
// - Status three bits 5:4 carry the sync clock state.
// - Status three bits 2:0: reverse active, input switch, battery switch.
`timescale 1ns/1ps
module crr_regs #(
  parameter int MPP_W = crr_pkg::MPP_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             reg_reset,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [7:0]       wr_data,
  input  wire logic [7:0]       rd_addr,
  output logic      [7:0]       rd_data,
  input  wire logic             mpp_valid,
  input  wire logic [MPP_W-1:0] peak_power_input_voltage,
  input  wire logic             conversion_done,
  input  wire logic             input_current_regulating,
  input  wire logic             input_voltage_regulating,
  input  wire logic             host_watchdog_expired,
  input  wire logic [2:0]       charge_state,
  input  wire logic             input_power_good,
  input  wire logic [2:0]       thermistor_zone,
  input  wire logic [1:0]       sync_clock_state,
  input  wire logic             reverse_active,
  input  wire logic             input_path_switch_on,
  input  wire logic             battery_switch_on,
  output logic      [1:0]       reverse_hot_limit_sel,
  output logic                  reverse_cold_limit_sel,
  output logic                  reverse_sys_undervolt_sel
);

  logic [MPP_W-1:0] mpp;
  logic [7:0]       stat_one;
  logic [7:0]       stat_two;
  logic [7:0]       stat_three;

  // Address match shared by the write strobes and the read selects
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // Only the two control addresses hold writable bits
  wire logic             wr_therm  = wr_en && addr_hit(wr_addr, crr_pkg::ADDR_THERM_CTRL);
  wire logic             wr_uv     = wr_en && addr_hit(wr_addr, crr_pkg::ADDR_UV_CTRL);

  // One read select per mapped byte
  wire logic             sel_therm = addr_hit(rd_addr, crr_pkg::ADDR_THERM_CTRL);
  wire logic             sel_uv    = addr_hit(rd_addr, crr_pkg::ADDR_UV_CTRL);
  wire logic             sel_lo    = addr_hit(rd_addr, crr_pkg::ADDR_MPP_LOW);
  wire logic             sel_hi    = addr_hit(rd_addr, crr_pkg::ADDR_MPP_HIGH);
  wire logic             sel_one   = addr_hit(rd_addr, crr_pkg::ADDR_STATUS_ONE);
  wire logic             sel_two   = addr_hit(rd_addr, crr_pkg::ADDR_STATUS_TWO);
  wire logic             sel_three = addr_hit(rd_addr, crr_pkg::ADDR_STATUS_THREE);
  wire logic             rd_mapped = sel_therm || sel_uv || sel_lo || sel_hi ||
                                     sel_one || sel_two || sel_three;
  wire logic [MPP_W-1:0] mpp_clamp = (peak_power_input_voltage > MPP_W'(crr_pkg::MPP_MAX)) ?
                                     MPP_W'(crr_pkg::MPP_MAX) : peak_power_input_voltage;
  wire logic [15:0]      mpp_word  = 16'(mpp) << crr_pkg::MPP_LSB;

  // Writable fields; register reset acts like the power-on reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reverse_hot_limit_sel     <= crr_pkg::HOT_RESET;
      reverse_cold_limit_sel    <= crr_pkg::COLD_RESET;
      reverse_sys_undervolt_sel <= crr_pkg::UV_RESET;
    end else if (reg_reset) begin
      reverse_hot_limit_sel     <= crr_pkg::HOT_RESET;
      reverse_cold_limit_sel    <= crr_pkg::COLD_RESET;
      reverse_sys_undervolt_sel <= crr_pkg::UV_RESET;
    end else begin
      if (wr_therm) begin
        reverse_hot_limit_sel  <= wr_data[crr_pkg::HOT_MSB:crr_pkg::HOT_LSB];
        reverse_cold_limit_sel <= wr_data[crr_pkg::COLD_BIT];
      end
      if (wr_uv) begin
        reverse_sys_undervolt_sel <= wr_data[crr_pkg::UV_BIT];
      end
    end
  end

  // Writes land one edge later; register reset wins over a write in the same cycle
  a_hot_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_therm && !reg_reset |=>
      reverse_hot_limit_sel == $past(wr_data[crr_pkg::HOT_MSB:crr_pkg::HOT_LSB]))
    else $error("hot threshold write lost");

  a_cold_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_therm && !reg_reset |=>
      reverse_cold_limit_sel == $past(wr_data[crr_pkg::COLD_BIT]))
    else $error("cold threshold write lost");

  a_uv_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    wr_uv && !reg_reset |=>
      reverse_sys_undervolt_sel == $past(wr_data[crr_pkg::UV_BIT]))
    else $error("undervoltage select write lost");

  a_hot_reset_val: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(reg_reset) |-> reverse_hot_limit_sel == crr_pkg::HOT_RESET)
    else $error("hot threshold not at default after register reset");

  a_cold_reset_val: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(reg_reset) |-> reverse_cold_limit_sel == crr_pkg::COLD_RESET)
    else $error("cold threshold not at default after register reset");

  a_uv_reset_val: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(reg_reset) |-> reverse_sys_undervolt_sel == crr_pkg::UV_RESET)
    else $error("undervoltage select not at default after register reset");

  // Writes to any other address must not disturb the control fields
  a_therm_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !wr_therm && !reg_reset |=>
      reverse_hot_limit_sel == $past(reverse_hot_limit_sel) &&
      reverse_cold_limit_sel == $past(reverse_cold_limit_sel))
    else $error("threshold fields changed without a write");

  a_uv_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !wr_uv && !reg_reset |=> reverse_sys_undervolt_sel == $past(reverse_sys_undervolt_sel))
    else $error("undervoltage select changed without a write");

  // Peak-power readback holds the last detected value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mpp <= '0;
    end else if (mpp_valid) begin
      mpp <= mpp_clamp;
    end
  end

  // Capture clamps to the top code; nothing else moves the stored value
  a_mpp_por: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> mpp == '0)
    else $error("peak-power value not zero after reset");

  a_mpp_clamp: assert property (
    @(posedge clk_sys) disable iff (rst)
    mpp_valid |=> mpp <= MPP_W'(crr_pkg::MPP_MAX))
    else $error("peak-power value above clamp");

  a_mpp_top: assert property (
    @(posedge clk_sys) disable iff (rst)
    mpp_valid && peak_power_input_voltage > MPP_W'(crr_pkg::MPP_MAX) |=>
      mpp == MPP_W'(crr_pkg::MPP_MAX))
    else $error("peak-power value not clamped to the top code");

  a_mpp_capture: assert property (
    @(posedge clk_sys) disable iff (rst)
    mpp_valid && peak_power_input_voltage <= MPP_W'(crr_pkg::MPP_MAX) |=>
      mpp == $past(peak_power_input_voltage))
    else $error("peak-power value not captured");

  a_mpp_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !mpp_valid |=> mpp == $past(mpp))
    else $error("peak-power value changed without a capture");

  // Status snapshots, registered so reads see stable data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_one   <= 8'h00;
      stat_two   <= 8'h00;
      stat_three <= 8'h00;
    end else begin
      stat_one   <= {conversion_done, input_current_regulating, input_voltage_regulating,
                     1'b0, host_watchdog_expired, charge_state};
      stat_two   <= {input_power_good, thermistor_zone, 4'h0};
      stat_three <= {2'h0, sync_clock_state, 1'b0, reverse_active,
                     input_path_switch_on, battery_switch_on};
    end
  end

  // Status reads show the level sampled one edge earlier; the edge after reset reads zero
  a_done_bit: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_one && !$past(rst) |-> rd_data[7] == $past(conversion_done))
    else $error("conversion complete bit wrong");

  a_current_reg: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_one && !$past(rst) |-> rd_data[6] == $past(input_current_regulating))
    else $error("input current regulation bit wrong");

  a_voltage_reg: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_one && !$past(rst) |-> rd_data[5] == $past(input_voltage_regulating))
    else $error("input voltage regulation bit wrong");

  a_stat_one_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_one && !$past(rst) |->
      rd_data[4] == 1'b0 && rd_data[3] == $past(host_watchdog_expired))
    else $error("status one watchdog bit wrong");

  a_charge_code: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_one && !$past(rst) |-> rd_data[2:0] == $past(charge_state))
    else $error("charge state code wrong");

  a_good_zone: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_two && !$past(rst) |->
      rd_data == {$past(input_power_good), $past(thermistor_zone), 4'h0})
    else $error("status two contents wrong");

  a_stat_pad: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_two |-> rd_data[3:0] == 4'h0)
    else $error("status two reserved bits set");

  a_sync_state: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_three && !$past(rst) |->
      rd_data[7:3] == {2'h0, $past(sync_clock_state), 1'b0})
    else $error("sync clock state bits wrong");

  a_reverse_bit: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_three && !$past(rst) |-> rd_data[2] == $past(reverse_active))
    else $error("reverse mode bit wrong");

  a_switch_bits: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_three && !$past(rst) |->
      rd_data[1:0] == {$past(input_path_switch_on), $past(battery_switch_on)})
    else $error("switch state bits wrong");

  // Read selection; unmapped addresses and reserved bits read zero
  wire logic [7:0]       therm_view = {reverse_hot_limit_sel, reverse_cold_limit_sel, 5'h00};
  wire logic [7:0]       uv_view    = {2'h0, reverse_sys_undervolt_sel, 5'h00};

  assign rd_data = ({8{sel_therm}} & therm_view)     |
                   ({8{sel_uv}}    & uv_view)        |
                   ({8{sel_lo}}    & mpp_word[7:0])  |
                   ({8{sel_hi}}    & mpp_word[15:8]) |
                   ({8{sel_one}}   & stat_one)       |
                   ({8{sel_two}}   & stat_two)       |
                   ({8{sel_three}} & stat_three);

  a_therm_view: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_therm |-> rd_data[7:5] == {reverse_hot_limit_sel, reverse_cold_limit_sel})
    else $error("threshold fields not read back");

  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_therm |-> rd_data[4:0] == 5'h00)
    else $error("reserved bits not zero");

  a_uv_reserved: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_uv |-> rd_data[7:6] == 2'h0 && rd_data[4:0] == 5'h00)
    else $error("undervoltage register reserved bits set");

  a_unmapped_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    !rd_mapped |-> rd_data == 8'h00)
    else $error("unmapped address read not zero");

  a_mpp_low_val: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_lo |-> rd_data == {6'(mpp), 2'h0})
    else $error("lower peak-power byte wrong");

  a_mpp_bytes: assert property (
    @(posedge clk_sys) disable iff (rst)
    sel_hi |-> rd_data == {2'h0, 6'(mpp >> 6)})
    else $error("upper peak-power byte wrong");

endmodule

// [bench/crr_host.sv]
// Host model driving register writes and the read address
`timescale 1ns/1ps
module crr_host (
  input  wire logic       clk_sys,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr
);
  initial begin
    {wr_en, wr_addr, wr_data, rd_addr} = '0;
  end
  // Held up to the taking edge, then the bus shows inverted leftovers
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(posedge clk_sys);
    #1;
    {wr_en, wr_addr, wr_data} = {1'b0, ~a, ~d};
  endtask
  task automatic point(input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    rd_addr = a;
    #10;
  endtask
endmodule

// [bench/crr_regs_tb.sv]
// Self-checking bench for the reverse config and status register slice
`timescale 1ns/1ps
module crr_regs_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        reg_reset = 1'b0;
  logic        mpp_valid = 1'b0;
  logic [11:0] peak_power_input_voltage = 12'h000;
  logic        conversion_done, input_current_regulating, input_voltage_regulating;
  logic        host_watchdog_expired, input_power_good, reverse_active;
  logic        input_path_switch_on, battery_switch_on, wr_en;
  logic [2:0]  charge_state, thermistor_zone;
  logic [1:0]  sync_clock_state, reverse_hot_limit_sel;
  logic        reverse_cold_limit_sel, reverse_sys_undervolt_sel;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, exp, port;
  logic [31:0] r = 32'hC9AC;
  logic [11:0] v;
  logic [15:0] m;
  logic [7:0]  exp_q[$];
  int          errors = 0;
  int          cmp_count = 0;
  event        got;
  crr_regs u_dut (.clk_sys, .rst, .reg_reset, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data,
    .mpp_valid, .peak_power_input_voltage, .conversion_done, .input_current_regulating,
    .input_voltage_regulating, .host_watchdog_expired, .charge_state, .input_power_good,
    .thermistor_zone, .sync_clock_state, .reverse_active, .input_path_switch_on,
    .battery_switch_on, .reverse_hot_limit_sel, .reverse_cold_limit_sel,
    .reverse_sys_undervolt_sel);
  crr_host u_host (.clk_sys, .wr_en, .wr_addr, .wr_data, .rd_addr);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_host.point(a);
    exp_q.push_back(e);
    -> got;
  endtask
  // Control addresses are also checked against the field outputs
  always @(got) begin
    exp = exp_q.pop_front();
    port = rd_addr == 8'h1D ? {reverse_hot_limit_sel, reverse_cold_limit_sel, 5'h00} :
           rd_addr == 8'h1E ? {2'h0, reverse_sys_undervolt_sel, 5'h00} : rd_data;
    cmp_count++;
    if (rd_data !== exp || port !== exp) begin
      errors++;
      $display("mismatch reg %h exp %h rd %h port %h", rd_addr, exp, rd_data, port);
    end
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {conversion_done, input_current_regulating, input_voltage_regulating, host_watchdog_expired,
     charge_state, input_power_good, thermistor_zone, sync_clock_state, reverse_active,
     input_path_switch_on, battery_switch_on} = '0;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(8'h1D, 8'h40);
    for (int a = 8'h1E; a <= 8'h23; a++) rd(a[7:0], 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      u_host.write(8'h1D, {i[2:0], 5'h1F});
      rd(8'h1D, {i[2:0], 5'h00});
    end
    u_host.write(8'h1E, 8'hFF);
    rd(8'h1E, 8'h20);
    u_host.write(8'h21, 8'hFF);
    u_host.write(8'h1F, 8'hFF);
    rd(8'h1F, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h55, 8'h00);
    u_host.write(8'h1D, 8'hA0);
    @(posedge clk_sys);
    #1 reg_reset = 1'b1;
    @(posedge clk_sys);
    #1 reg_reset = 1'b0;
    rd(8'h1D, 8'h40);
    rd(8'h1E, 8'h00);
    $display("test control fields done");
    for (int i = 0; i < 4; i++) begin
      r = step(r);
      v = i == 0 ? 12'hFFF : i == 1 ? 12'hBB8 : r[11:0];
      m = {2'h0, v > 12'hBB8 ? 12'hBB8 : v, 2'h0};
      @(posedge clk_sys);
      #1 {mpp_valid, peak_power_input_voltage} = {1'b1, v};
      @(posedge clk_sys);
      #1 {mpp_valid, peak_power_input_voltage} = {1'b0, ~v};
      rd(8'h1F, m[7:0]);
      rd(8'h20, m[15:8]);
    end
    $display("test peak voltage done");
    for (int i = 0; i < 8; i++) begin
      r = step(r);
      @(posedge clk_sys);
      #1 {conversion_done, input_current_regulating, input_voltage_regulating,
          host_watchdog_expired, input_power_good, sync_clock_state, reverse_active,
          input_path_switch_on, battery_switch_on, charge_state, thermistor_zone} =
          {r[9:0], i[2:0], i[2:0] % 3'h5};
      rd(8'h21, {r[9:7], 1'b0, r[6], i[2:0]});
      rd(8'h22, {r[5], thermistor_zone, 4'h0});
      rd(8'h23, {2'h0, r[4:3], 1'b0, r[2:0]});
    end
    $display("test status done");
    tally_and_finish();
  end
endmodule
